// ==== hdl/imd_pkg.sv ====
/*
  Constants, field layouts and carrier types for the integer multiply,
  divide and remainder unit. Assumes one core clock and a synchronous
  active-low reset; no registers are reachable by software.
*/
// Overview of operation
// - accept only major opcode 011111 with bits 10..6 zero; low six bits pick the op
// - signed word multiply: low 32 product bits, sign-extended, to destination
// - unsigned word multiply: zero-extended low words, low 32 product bits sign-extended
// - signed doubleword multiply: low 64 bits of the 128-bit signed product
// - unsigned doubleword multiply: low 64 bits of the 128-bit unsigned product
// - signed word divide: sign-extended 32-bit quotient
// - unsigned word divide: sign-extended low 32 quotient bits
// - signed doubleword divide: 64-bit quotient
// - unsigned doubleword divide: 64-bit quotient
// - signed word remainder: sign-extended 32-bit remainder
// - unsigned word remainder: sign-extended low 32 remainder bits
// - signed doubleword remainder: 64-bit remainder
// - unsigned doubleword remainder: 64-bit remainder
// - no arithmetic exception ever, overflow included
// - word operations use only source bits 31..0
package imd_pkg;

  // ***************************************************************
  // instruction fields
  // ***************************************************************
  localparam int IMD_OPC_POS = 26;
  localparam int IMD_ZERO_POS = 6;
  localparam int IMD_RD_POS = 11;
  localparam logic [5:0] IMD_OPC_EXT = 6'h1F;
  localparam logic [4:0] IMD_ZERO_FIELD = 5'h00;

  localparam logic [5:0] IMD_FN_SW_MUL = 6'h18;
  localparam logic [5:0] IMD_FN_UW_MUL = 6'h19;
  localparam logic [5:0] IMD_FN_SW_DIV = 6'h1A;
  localparam logic [5:0] IMD_FN_UW_DIV = 6'h1B;
  localparam logic [5:0] IMD_FN_SD_MUL = 6'h1C;
  localparam logic [5:0] IMD_FN_UD_MUL = 6'h1D;
  localparam logic [5:0] IMD_FN_SD_DIV = 6'h1E;
  localparam logic [5:0] IMD_FN_UD_DIV = 6'h1F;
  localparam logic [5:0] IMD_FN_SW_REM = 6'h22;
  localparam logic [5:0] IMD_FN_UW_REM = 6'h23;
  localparam logic [5:0] IMD_FN_SD_REM = 6'h26;
  localparam logic [5:0] IMD_FN_UD_REM = 6'h27;

  // ***************************************************************
  // reset values and timing
  // ***************************************************************
  localparam logic [63:0] IMD_RESULT_RST = 64'h0000_0000_0000_0000;
  localparam int IMD_DIV_STEPS = 64;

  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] src_a;
    logic [63:0] src_b;
  } imd_issue_type;

  typedef struct packed {
    logic [4:0] dest;
    logic [63:0] value;
  } imd_wb_type;

endpackage : imd_pkg

// ==== hdl/imd_divider.sv ====
/*
  Iterative restoring divider on magnitudes, one quotient bit per cycle.
  Assumes the caller holds no request while busy and handles signs.
*/
`timescale 1ns/1ps
module imd_divider
  import imd_pkg::*;
#(
  parameter int WIDTH = 64
)
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] dividend_in,
  input wire logic [WIDTH-1:0] divisor_in,
  output logic busy_out,
  output logic done_out,
  output logic [WIDTH-1:0] quot_out,
  output logic [WIDTH-1:0] rem_out
);

  if (WIDTH < 2 || WIDTH > 64)
  begin : g_width_check
    $error("imd_divider: WIDTH out of range");
  end

  logic [WIDTH-1:0] quot;
  logic [WIDTH-1:0] rem;
  logic [WIDTH-1:0] dsr;
  logic [6:0] count;
  logic busy;
  logic done;
  wire logic [WIDTH:0] shifted = {rem, quot[WIDTH-1]};
  wire logic [WIDTH:0] trial = shifted - {1'b0, dsr};
  wire logic fits = ~trial[WIDTH];
  wire logic last = (count == 7'(WIDTH - 1));

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 7'h00;
      quot <= '0;
      rem <= '0;
      dsr <= '0;
    end
    else if (start_in && !busy)
    begin
      busy <= 1'b1;
      done <= 1'b0;
      count <= 7'h00;
      quot <= dividend_in;
      rem <= '0;
      dsr <= divisor_in;
    end
    else if (busy)
    begin
      rem <= fits ? trial[WIDTH-1:0] : shifted[WIDTH-1:0];
      quot <= {quot[WIDTH-2:0], fits};
      count <= count + 7'h01;
      busy <= !last;
      done <= last;
    end
    else
    begin
      done <= 1'b0;
    end
  end

  // zero divisor falls out naturally: all-ones quotient, dividend remainder
  assign busy_out = busy;
  assign done_out = done;
  assign quot_out = quot;
  assign rem_out = rem;

endmodule : imd_divider

// ==== hdl/imd_unit.sv ====
/*
  Integer multiply, divide and remainder execution unit for twelve
  extension instructions. Assumes the issue stage presents one request
  at a time and waits on busy, and that writeback takes the result pulse.
*/
`timescale 1ns/1ps
module imd_unit
  import imd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic issue_valid_in,
  input wire imd_issue_type issue_in,
  output logic issue_ready_out,
  output logic accepted_out,
  output logic busy_out,
  output logic result_valid_out,
  output imd_wb_type result_out,
  output logic exception_out
);

  // ***************************************************************
  // decode
  // ***************************************************************
  typedef enum logic [1:0] {
    IMD_IDLE = 2'b00,
    IMD_DIVIDE = 2'b01,
    IMD_FINISH = 2'b11
  } imd_state_type;

  imd_state_type state;
  imd_state_type next_state;

  wire logic [5:0] opc = issue_in.instr[31:IMD_OPC_POS];
  wire logic [4:0] zero_field = issue_in.instr[10:IMD_ZERO_POS];
  wire logic [5:0] fn = issue_in.instr[5:0];
  wire logic [4:0] dest = issue_in.instr[15:IMD_RD_POS];
  wire logic ext_hit = (opc == IMD_OPC_EXT) && (zero_field == IMD_ZERO_FIELD);

  wire logic is_sw_mul = (fn == IMD_FN_SW_MUL);
  wire logic is_uw_mul = (fn == IMD_FN_UW_MUL);
  wire logic is_sd_mul = (fn == IMD_FN_SD_MUL);
  wire logic is_ud_mul = (fn == IMD_FN_UD_MUL);
  wire logic is_mul = is_sw_mul || is_uw_mul || is_sd_mul || is_ud_mul;
  wire logic is_sw_div = (fn == IMD_FN_SW_DIV);
  wire logic is_uw_div = (fn == IMD_FN_UW_DIV);
  wire logic is_sd_div = (fn == IMD_FN_SD_DIV);
  wire logic is_ud_div = (fn == IMD_FN_UD_DIV);
  wire logic is_sw_rem = (fn == IMD_FN_SW_REM);
  wire logic is_uw_rem = (fn == IMD_FN_UW_REM);
  wire logic is_sd_rem = (fn == IMD_FN_SD_REM);
  wire logic is_ud_rem = (fn == IMD_FN_UD_REM);
  wire logic is_rem = is_sw_rem || is_uw_rem || is_sd_rem || is_ud_rem;
  wire logic is_div = is_sw_div || is_uw_div || is_sd_div || is_ud_div || is_rem;
  wire logic is_word = is_sw_mul || is_uw_mul || is_sw_div || is_uw_div
                    || is_sw_rem || is_uw_rem;
  wire logic is_signed = is_sw_mul || is_sd_mul || is_sw_div || is_sd_div
                      || is_sw_rem || is_sd_rem;
  // unlisted codes under the extension opcode still answer, as an unsigned
  // doubleword quotient, so an issuer waiting on the result cannot hang
  wire logic is_spare = !is_mul && !is_div;

  wire logic take = issue_valid_in && (state == IMD_IDLE) && ext_hit;
  wire logic take_mul = take && is_mul;
  wire logic take_div = take && (is_div || is_spare);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  localparam logic [5:0] IMD_FN_LIST [12] = '{IMD_FN_SW_MUL, IMD_FN_UW_MUL,
    IMD_FN_SD_MUL, IMD_FN_UD_MUL, IMD_FN_SW_DIV, IMD_FN_UW_DIV, IMD_FN_SD_DIV,
    IMD_FN_UD_DIV, IMD_FN_SW_REM, IMD_FN_UW_REM, IMD_FN_SD_REM, IMD_FN_UD_REM};

  // the fields must tile the word, or decode would read the wrong bits
  if (IMD_OPC_POS + 6 != 32)
  begin : g_opc_fit
    $error("imd_unit: opcode field must end at bit 31");
  end
  if (IMD_ZERO_POS + 5 != IMD_RD_POS)
  begin : g_zero_fit
    $error("imd_unit: zero field must sit right below the destination");
  end
  if (IMD_RD_POS + 5 != 16)
  begin : g_dest_fit
    $error("imd_unit: destination field must sit right below the sources");
  end
  // one divider step per quotient bit of a doubleword
  if (IMD_DIV_STEPS != 64)
  begin : g_steps_fit
    $error("imd_unit: divide steps must match the doubleword width");
  end
  // two equal codes would let one operation shadow another
  for (genvar i = 0; i < 11; i++)
  begin : g_fn_row
    for (genvar j = i + 1; j < 12; j++)
    begin : g_fn_col
      if (IMD_FN_LIST[i] == IMD_FN_LIST[j])
      begin : g_fn_clash
        $error("imd_unit: two function codes are equal");
      end
    end
  end

  // ***************************************************************
  // operand shaping
  // ***************************************************************
  // word forms see only the low half, extended per signedness
  wire logic [63:0] op_a = is_word
    ? {{32{is_signed & issue_in.src_a[31]}}, issue_in.src_a[31:0]}
    : issue_in.src_a;
  wire logic [63:0] op_b = is_word
    ? {{32{is_signed & issue_in.src_b[31]}}, issue_in.src_b[31:0]}
    : issue_in.src_b;

  // ***************************************************************
  // multiply, single cycle
  // ***************************************************************
  // low 64 bits of a 128-bit product are identical for signed and unsigned
  wire logic [127:0] prod_full = {64'h0000_0000_0000_0000, op_a}
                               * {64'h0000_0000_0000_0000, op_b};
  wire logic [63:0] prod_lo = prod_full[63:0];
  wire logic [63:0] mul_word = {{32{prod_lo[31]}}, prod_lo[31:0]};
  wire logic [63:0] mul_value = is_word ? mul_word : prod_lo;

  // ***************************************************************
  // divide, multi-cycle on magnitudes
  // ***************************************************************
  wire logic neg_a = is_signed && op_a[63];
  wire logic neg_b = is_signed && op_b[63];
  wire logic [63:0] mag_a = neg_a ? (64'h0000_0000_0000_0000 - op_a) : op_a;
  wire logic [63:0] mag_b = neg_b ? (64'h0000_0000_0000_0000 - op_b) : op_b;

  logic hold_rem;
  logic hold_word;
  logic hold_neg_q;
  logic hold_neg_r;
  logic hold_zero;
  logic [63:0] hold_a;
  logic [4:0] hold_dest;
  logic div_done;
  logic [63:0] div_quot;
  logic [63:0] div_rem;

  imd_divider #(
    .WIDTH(IMD_DIV_STEPS)
  ) u_divider (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .start_in(take_div),
    .dividend_in(mag_a),
    .divisor_in(mag_b),
    .busy_out(),
    .done_out(div_done),
    .quot_out(div_quot),
    .rem_out(div_rem)
  );

  // signs applied after the magnitude divide; min/-1 wraps, no trap
  wire logic [63:0] q_signed = hold_neg_q ? (64'h0000_0000_0000_0000 - div_quot)
                                          : div_quot;
  wire logic [63:0] r_signed = hold_neg_r ? (64'h0000_0000_0000_0000 - div_rem)
                                          : div_rem;
  // zero divisor: quotient all ones, remainder is the dividend
  wire logic [63:0] q_final = hold_zero ? 64'hFFFF_FFFF_FFFF_FFFF : q_signed;
  wire logic [63:0] r_final = hold_zero ? hold_a : r_signed;
  wire logic [63:0] div_pick = hold_rem ? r_final : q_final;
  wire logic [63:0] div_value = hold_word ? {{32{div_pick[31]}}, div_pick[31:0]}
                                          : div_pick;

  // ***************************************************************
  // sequencing
  // ***************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      IMD_IDLE:
        if (take_div)
          next_state = IMD_DIVIDE;
      IMD_DIVIDE:
        if (div_done)
          next_state = IMD_FINISH;
      IMD_FINISH:
        next_state = IMD_IDLE;
      default:
        next_state = IMD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
      state <= IMD_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      hold_rem <= 1'b0;
      hold_word <= 1'b0;
      hold_neg_q <= 1'b0;
      hold_neg_r <= 1'b0;
      hold_zero <= 1'b0;
      hold_a <= IMD_RESULT_RST;
      hold_dest <= 5'h00;
    end
    else if (take_div)
    begin
      hold_rem <= is_rem;
      hold_word <= is_word;
      hold_neg_q <= neg_a ^ neg_b;
      hold_neg_r <= neg_a;
      hold_zero <= (op_b == 64'h0000_0000_0000_0000);
      hold_a <= op_a;
      hold_dest <= dest;
    end
  end

  // ***************************************************************
  // writeback
  // ***************************************************************
  logic res_valid;
  imd_wb_type res;

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      res_valid <= 1'b0;
      res <= '{dest: 5'h00, value: IMD_RESULT_RST};
    end
    else if (take_mul)
    begin
      res_valid <= 1'b1;
      res <= '{dest: dest, value: mul_value};
    end
    else if (state == IMD_DIVIDE && div_done)
    begin
      res_valid <= 1'b1;
      res <= '{dest: hold_dest, value: div_value};
    end
    else
      res_valid <= 1'b0;
  end

  // busy covers the whole divide so the issuer holds dependents
  assign busy_out = (state != IMD_IDLE);
  assign issue_ready_out = (state == IMD_IDLE);
  assign accepted_out = take;
  assign result_valid_out = res_valid;
  assign result_out = res;
  assign exception_out = 1'b0;

endmodule : imd_unit

// ==== dv/imd_unit_monitor.sv ====
/* port checker for the multiply, divide and remainder unit;
   bound to every imd_unit, single clock domain */
`timescale 1ns/1ps
module imd_unit_monitor
  import imd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic issue_valid_in,
  input wire imd_issue_type issue_in,
  input wire logic issue_ready_out,
  input wire logic accepted_out,
  input wire logic busy_out,
  input wire logic result_valid_out,
  input wire imd_wb_type result_out,
  input wire logic exception_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  wire logic [5:0] fn = issue_in.instr[5:0];
  wire logic opc_ok = issue_in.instr[31:26] == IMD_OPC_EXT
    && issue_in.instr[10:6] == IMD_ZERO_FIELD;
  wire logic mul_fn = fn inside {IMD_FN_SW_MUL, IMD_FN_UW_MUL, IMD_FN_SD_MUL, IMD_FN_UD_MUL};
  wire logic is_mul = accepted_out && mul_fn;
  wire logic is_div = accepted_out && !mul_fn;
  sequence s_div_quiet;
    !result_valid_out [*8];
  endsequence
  property p_no_exc;
    !exception_out;
  endproperty
  property p_take;
    accepted_out |-> issue_valid_in && issue_ready_out && opc_ok;
  endproperty
  property p_mul_lat;
    is_mul |=> result_valid_out && result_out.dest == $past(issue_in.instr[15:11]);
  endproperty
  property p_ud_mul;
    accepted_out && fn == IMD_FN_UD_MUL
      |=> result_out.value == $past(issue_in.src_a) * $past(issue_in.src_b);
  endproperty
  property p_word_sx;
    accepted_out && fn == IMD_FN_SW_MUL |=> result_out.value[63:32] == {32{result_out.value[31]}};
  endproperty
  property p_div_lat;
    is_div |=> s_div_quiet ##58 result_valid_out;
  endproperty
  property p_busy_rise;
    is_div |=> busy_out [*3];
  endproperty
  property p_busy_block;
    busy_out |-> !issue_ready_out && !accepted_out;
  endproperty
  property p_busy_end;
    $fell(busy_out) |-> $past(result_valid_out);
  endproperty
  a_no_exc: assert property (p_no_exc) else $error("exception raised");
  a_take: assert property (p_take) else $error("bad accept");
  a_mul_lat: assert property (p_mul_lat) else $error("multiply answer late");
  a_ud_mul: assert property (p_ud_mul) else $error("unsigned product wrong");
  a_word_sx: assert property (p_word_sx) else $error("word not sign-extended");
  a_div_lat: assert property (p_div_lat) else $error("divide answer timing");
  a_busy_rise: assert property (p_busy_rise) else $error("busy missing");
  a_busy_block: assert property (p_busy_block) else $error("accept while busy");
  a_busy_end: assert property (p_busy_end) else $error("busy fell early");
endmodule : imd_unit_monitor

bind imd_unit imd_unit_monitor u_imd_unit_monitor (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .issue_valid_in(issue_valid_in), .issue_in(issue_in),
  .issue_ready_out(issue_ready_out), .accepted_out(accepted_out), .busy_out(busy_out),
  .result_valid_out(result_valid_out), .result_out(result_out), .exception_out(exception_out));

// ==== dv/imd_issue_model.sv ====
/* issue-stage model: presents one request and waits for its result;
   assumes the unit samples on the rising clock edge */
`timescale 1ns/1ps
module imd_issue_model
  import imd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic accepted_in,
  input wire logic result_valid_in,
  input wire imd_wb_type result_in,
  output logic issue_valid_out,
  output imd_issue_type issue_out
);
  initial
  begin
    issue_valid_out = 1'b0;
    issue_out = '0;
  end
  task automatic send(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
    output logic [63:0] val, output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    #1;
    issue_valid_out = 1'b1;
    issue_out = {ins, a, b};
    // look at accept once settled, before the edge that takes the request
    #1;
    while (!accepted_in && n < 4)
    begin
      @(posedge clk_sys_in);
      #2;
      n++;
    end
    ok = accepted_in;
    @(posedge clk_sys_in);
    #1;
    // released request must not look like a live one
    issue_valid_out = 1'b0;
    issue_out = ~issue_out;
    n = 0;
    while (ok && !result_valid_in && n < 100)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    ok = ok && result_valid_in;
    val = result_in.value;
  endtask : send
endmodule : imd_issue_model

// ==== dv/tb_imd_unit.sv ====
/* self-checking bench for imd_unit, driven through the issue model;
   expected values computed here */
`timescale 1ns/1ps
module tb_imd_unit
  import imd_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic issue_valid, ready, accepted, busy, res_valid, exc;
  imd_issue_type issue;
  imd_wb_type result;
  int err_total = 0;
  int n_compared = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  imd_unit u_imd_unit (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .issue_valid_in(issue_valid), .issue_in(issue), .issue_ready_out(ready),
    .accepted_out(accepted), .busy_out(busy), .result_valid_out(res_valid),
    .result_out(result), .exception_out(exc));
  imd_issue_model u_imd_issue_model (.clk_sys_in(clk_sys_in), .accepted_in(accepted),
    .result_valid_in(res_valid), .result_in(result), .issue_valid_out(issue_valid),
    .issue_out(issue));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit
  function automatic logic [63:0] calc(input logic [5:0] fn, input logic [63:0] a,
    input logic [63:0] b);
    logic signed [63:0] sa, sb, r;
    logic [63:0] ua, ub;
    sa = {{32{a[31]}}, a[31:0]};
    sb = {{32{b[31]}}, b[31:0]};
    ua = {32'h0000_0000, a[31:0]};
    ub = {32'h0000_0000, b[31:0]};
    case (fn)
      IMD_FN_SW_MUL: r = sa * sb;
      IMD_FN_UW_MUL: r = ua * ub;
      IMD_FN_SW_DIV: r = sa / sb;
      IMD_FN_UW_DIV: r = ua / ub;
      IMD_FN_SW_REM: r = sa % sb;
      IMD_FN_UW_REM: r = ua % ub;
      IMD_FN_SD_DIV: r = $signed(a) / $signed(b);
      IMD_FN_SD_REM: r = $signed(a) % $signed(b);
      IMD_FN_UD_DIV: r = a / b;
      IMD_FN_UD_REM: r = a % b;
      default: r = a * b;
    endcase
    // word forms all have function bit 2 clear
    if (!fn[2])
      r = {{32{r[31]}}, r[31:0]};
    return r;
  endfunction : calc
  task automatic run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
    input logic [63:0] exp, input logic want_ok);
    logic [63:0] v;
    logic ok;
    u_imd_issue_model.send(ins, a, b, v, ok);
    cmp_bit(ok, want_ok);
    if (want_ok)
    begin
      cmp(v, exp);
      cmp({59'h0, result.dest}, {59'h0, ins[15:11]});
    end
    cmp_bit(exc, 1'b0);
  endtask : run
  task automatic chk(input logic [5:0] fn, input logic [63:0] a, input logic [63:0] b,
    input logic [63:0] exp);
    run({IMD_OPC_EXT, 10'h083, fn[4:0], IMD_ZERO_FIELD, fn}, a, b, exp, 1'b1);
  endtask : chk
  task automatic t_mul;
    logic [63:0] a, b;
    a = 64'hDEAD_BEEF_8000_0003;
    b = 64'h1234_5678_FFFF_FFFE;
    chk(IMD_FN_SW_MUL, a, b, calc(IMD_FN_SW_MUL, a, b));
    chk(IMD_FN_UW_MUL, a, b, calc(IMD_FN_UW_MUL, a, b));
    chk(IMD_FN_SD_MUL, 64'hFFFF_FFFF_FFFF_FFFD, b, 64'hC962_FC95_0000_0006);
    chk(IMD_FN_UD_MUL, a, b, a * b);
  endtask : t_mul
  task automatic t_divrem;
    logic [5:0] f [8] = '{IMD_FN_SW_DIV, IMD_FN_UW_DIV, IMD_FN_SW_REM, IMD_FN_UW_REM,
      IMD_FN_SD_DIV, IMD_FN_UD_DIV, IMD_FN_SD_REM, IMD_FN_UD_REM};
    logic [63:0] a [2] = '{64'h5555_5555_8765_4321, 64'h8000_0000_0000_0123};
    logic [63:0] b [2] = '{64'hAAAA_AAAA_0000_0007, 64'hFFFF_FFFF_FFFF_FFF9};
    foreach (f[i])
      foreach (a[j])
        chk(f[i], a[j], b[j], calc(f[i], a[j], b[j]));
  endtask : t_divrem
  task automatic t_corner;
    chk(IMD_FN_SD_DIV, 64'h0000_0000_0000_0005, '0, 64'hFFFF_FFFF_FFFF_FFFF);
    chk(IMD_FN_SW_DIV, 64'h1111_1111_0000_0005, '0, 64'hFFFF_FFFF_FFFF_FFFF);
    chk(IMD_FN_UD_REM, 64'h8765_4321_0FED_CBA9, '0, 64'h8765_4321_0FED_CBA9);
    chk(IMD_FN_SW_REM, 64'h1111_1111_9000_0001, '0, 64'hFFFF_FFFF_9000_0001);
    chk(IMD_FN_SD_DIV, 64'h8000_0000_0000_0000, '1, 64'h8000_0000_0000_0000);
    chk(IMD_FN_SD_REM, 64'h8000_0000_0000_0000, '1, 64'h0000_0000_0000_0000);
    chk(IMD_FN_SW_DIV, 64'h0000_0000_8000_0000, '1, 64'hFFFF_FFFF_8000_0000);
    chk(6'h00, 64'h0000_0000_0000_0064, 64'h0000_0000_0000_0005, 64'h0000_0000_0000_0014);
  endtask : t_corner
  task automatic t_refuse;
    run({6'h1E, 10'h083, 5'h01, IMD_ZERO_FIELD, IMD_FN_UD_MUL}, 1, 1, 0, 1'b0);
    run({IMD_OPC_EXT, 10'h083, 5'h01, 5'h04, IMD_FN_UD_MUL}, 1, 1, 0, 1'b0);
  endtask : t_refuse
  task automatic finish_test;
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    resetn_in = 1'b1;
    cmp_bit(ready, 1'b1);
    cmp_bit(busy, 1'b0);
    cmp_bit(res_valid, 1'b0);
    t_mul();
    t_divrem();
    t_corner();
    t_refuse();
    finish_test();
  end
endmodule : tb_imd_unit
